/* File: debug_lock_pkg.sv */
// Constants for the debug security lock
package debug_lock_pkg;
	localparam logic [31:0] security_mode_addr = 32'hffffe510;
	localparam logic [31:0] security_key_addr  = 32'hffffe514;
	localparam logic [31:0] unlock_key         = 32'h000000c5;
	localparam logic        security_on_reset  = 1'b1;
	localparam int          security_on_bit    = 0;
	// Probe target classes
	localparam logic [2:0]  tgt_core           = 3'h0;
	localparam logic [2:0]  tgt_ram            = 3'h1;
	localparam logic [2:0]  tgt_ext            = 3'h2;
	localparam logic [2:0]  tgt_rom            = 3'h3;
	localparam logic [2:0]  tgt_periph         = 3'h4;
endpackage

/* File: debug_security_lock.sv */
// Debug security lock: APB registers and probe access gating
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module debug_security_lock (
	input  wire logic        mclk,          // System clock, 250 MHz
	input  wire logic        rst,           // Synchronous reset, active high
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB access phase
	input  wire logic        pwrite,        // APB direction
	input  wire logic [31:0] paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic             pready,        // APB ready
	output logic      [31:0] prdata,        // APB read data
	output logic             pslverr,       // APB error, unmapped address
	input  wire logic        probe_req,     // Probe access request, same clock
	input  wire logic        probe_write,   // Probe access is a write
	input  wire logic [2:0]  probe_target,  // Probe target class
	output logic             probe_grant,   // Probe access allowed
	output logic             probe_deny,    // Probe access refused
	output logic             debug_enable   // Lock released, probe pins live
);
	typedef struct packed {
		logic        security_on;
		logic        unlocked;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic        grant;
		logic        deny;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic   setup;
	logic   hit_mode;
	logic   hit_key;
	logic   mode_write;
	logic   mode_read;
	logic   key_write;
	logic   key_match;
	logic   key_accept;
	logic   unmapped;
	logic   allowed;

	// ==========================================================
	// Register access
	// Pready blocks a second setup if penable comes late
	assign setup      = psel && !penable && !state_reg.pready;
	assign hit_mode   = paddr == debug_lock_pkg::security_mode_addr;
	assign hit_key    = paddr == debug_lock_pkg::security_key_addr;
	assign mode_write = setup && pwrite && hit_mode;
	assign mode_read  = setup && !pwrite && hit_mode;
	assign key_write  = setup && pwrite && hit_key;
	// Whole-word match, so a stray byte store can never unlock
	assign key_match  = pwdata == debug_lock_pkg::unlock_key;
	// Key counts only after security-on cleared; else no effect
	assign key_accept = key_write && !state_reg.security_on && key_match;
	assign unmapped   = setup && !(hit_mode || hit_key);

	// ==========================================================
	// Probe policy
	always_comb begin
		allowed = 1'b0;
		if (state_reg.unlocked) begin
			if (probe_write) begin
				allowed = probe_target == debug_lock_pkg::tgt_core ||
					probe_target == debug_lock_pkg::tgt_ram ||
					probe_target == debug_lock_pkg::tgt_ext;
			end else begin
				// Only ROM contents stay secret from probe reads
				allowed = probe_target != debug_lock_pkg::tgt_rom;
			end
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		state_next         = state_reg;
		state_next.pready  = 1'b0;
		state_next.pslverr = 1'b0;
		state_next.prdata  = 32'h00000000;
		// No wait state: answer in the first access-phase cycle after setup
		if (setup) begin
			state_next.pready  = 1'b1;
			state_next.pslverr = unmapped;
		end
		// Writes land at the setup edge, before pready is seen
		if (mode_write) begin
			state_next.security_on = pwdata[debug_lock_pkg::security_on_bit];
		end
		// Setting security-on again does not relock; only reset does
		if (key_accept) begin
			state_next.unlocked = 1'b1;
		end
		// Other bits stay zero: the word is always read whole
		if (mode_read) begin
			state_next.prdata[debug_lock_pkg::security_on_bit] = state_reg.security_on;
		end
		state_next.grant = probe_req && allowed;
		state_next.deny  = probe_req && !allowed;
		if (rst) begin
			state_next             = '0;
			state_next.security_on = debug_lock_pkg::security_on_reset;
		end
	end

	// ==========================================================
	// State register
	// Reset folds into the next state, so one register process
	always_ff @(posedge mclk) begin
		state_reg <= state_next;
	end

	// ==========================================================
	// Outputs, all straight from the state register
	assign pready       = state_reg.pready;
	assign prdata       = state_reg.prdata;
	assign pslverr      = state_reg.pslverr;
	assign probe_grant  = state_reg.grant;
	assign probe_deny   = state_reg.deny;
	assign debug_enable = state_reg.unlocked;

	// ==========================================================
	// Checks: lock state
	a_reset_locks: assert property (@(posedge mclk) rst |=> !debug_enable && !probe_grant)
		else $error("lock not engaged after reset");
	a_reset_security_on: assert property (@(posedge mclk)
		rst |=> state_reg.security_on && !state_reg.unlocked)
		else $error("security-on not set after reset");
	a_unlock_cause: assert property (@(posedge mclk) disable iff (rst)
		$rose(debug_enable) |-> $past(setup && pwrite && hit_key && !state_reg.security_on
		&& pwdata == debug_lock_pkg::unlock_key))
		else $error("unlock without proper sequence");
	a_key_when_on: assert property (@(posedge mclk) disable iff (rst)
		setup && pwrite && hit_key && state_reg.security_on && !debug_enable |=> !debug_enable)
		else $error("key accepted with security on");
	a_wrong_key_keeps: assert property (@(posedge mclk) disable iff (rst)
		key_write && !key_match && !debug_enable |=> !debug_enable)
		else $error("wrong key released the lock");
	a_lock_hold: assert property (@(posedge mclk) disable iff (rst)
		!key_accept && !debug_enable |=> !debug_enable)
		else $error("lock released without key write");
	a_pin_follows: assert property (@(posedge mclk) disable iff (rst)
		debug_enable |=> debug_enable)
		else $error("lock re-engaged without reset");

	// ==========================================================
	// Checks: register bus
	a_setup_answers: assert property (@(posedge mclk) disable iff (rst)
		setup |=> pready)
		else $error("setup not answered in next cycle");
	a_ready_single: assert property (@(posedge mclk) disable iff (rst)
		pready |=> !pready)
		else $error("pready held past one cycle");
	a_unmapped_error: assert property (@(posedge mclk) disable iff (rst)
		unmapped |=> pslverr)
		else $error("unmapped access without error");
	a_mapped_no_error: assert property (@(posedge mclk) disable iff (rst)
		setup && !unmapped |=> !pslverr)
		else $error("mapped access flagged as error");
	a_mode_readback: assert property (@(posedge mclk) disable iff (rst)
		setup && !pwrite && hit_mode |=> prdata == {31'h0, state_reg.security_on} && pready)
		else $error("mode register read wrong");
	a_mode_write_takes: assert property (@(posedge mclk) disable iff (rst)
		mode_write |=> state_reg.security_on == $past(pwdata[debug_lock_pkg::security_on_bit]))
		else $error("mode register write lost");
	a_secure_hold: assert property (@(posedge mclk) disable iff (rst)
		!mode_write |=> $stable(state_reg.security_on))
		else $error("security-on changed without a write");
	a_idle_data_zero: assert property (@(posedge mclk) disable iff (rst)
		!mode_read |=> prdata == '0)
		else $error("read data not zero outside a mode read");

	// ==========================================================
	// Checks: probe policy
	a_locked_denies: assert property (@(posedge mclk) disable iff (rst)
		probe_req && !state_reg.unlocked |=> probe_deny && !probe_grant)
		else $error("locked probe access granted");
	a_grant_needs_unlock: assert property (@(posedge mclk) disable iff (rst)
		probe_grant |-> $past(state_reg.unlocked))
		else $error("probe granted while locked");
	a_answer_exclusive: assert property (@(posedge mclk) disable iff (rst)
		!(probe_grant && probe_deny))
		else $error("probe granted and denied at once");
	a_no_request_quiet: assert property (@(posedge mclk) disable iff (rst)
		!probe_req |=> !probe_grant && !probe_deny)
		else $error("probe answer without request");
	a_rom_read_blocked: assert property (@(posedge mclk) disable iff (rst)
		probe_req && !probe_write && probe_target == debug_lock_pkg::tgt_rom |=> !probe_grant)
		else $error("probe read of rom granted");
	a_periph_write_blocked: assert property (@(posedge mclk) disable iff (rst)
		probe_req && probe_write && probe_target == debug_lock_pkg::tgt_periph |=> probe_deny)
		else $error("probe write to peripheral granted");
	a_unlocked_read_ok: assert property (@(posedge mclk) disable iff (rst)
		probe_req && !probe_write && state_reg.unlocked && probe_target != debug_lock_pkg::tgt_rom
		|=> probe_grant)
		else $error("allowed probe read denied");
	a_unlocked_write_ok: assert property (@(posedge mclk) disable iff (rst)
		probe_req && probe_write && state_reg.unlocked && (probe_target == debug_lock_pkg::tgt_core
		|| probe_target == debug_lock_pkg::tgt_ram || probe_target == debug_lock_pkg::tgt_ext)
		|=> probe_grant)
		else $error("allowed probe write denied");

	// Main scenarios
	c_unlock: cover property (@(posedge mclk) $rose(debug_enable));
	c_grant: cover property (@(posedge mclk) probe_grant);
	c_bad_key: cover property (@(posedge mclk) setup && pwrite && hit_key && pwdata != debug_lock_pkg::unlock_key);
	c_rom_denied: cover property (@(posedge mclk) state_reg.unlocked && probe_req && !probe_write
		&& probe_target == debug_lock_pkg::tgt_rom ##1 probe_deny);
	c_relock: cover property (@(posedge mclk) $fell(debug_enable));
endmodule
`default_nettype wire

/* File: probe_model.sv */
// Debug probe model issuing one access at a time
`timescale 1ns/1ps
`default_nettype none
module probe_model (
	input  wire logic       mclk,  // System clock
	output logic            req,   // Access request
	output logic            wr,    // Access is a write
	output logic      [2:0] tgt,   // Target class
	input  wire logic       grant, // Access allowed
	input  wire logic       deny   // Access refused
);
	initial {req, wr, tgt} = '0;
	task automatic access(input logic w, input logic [2:0] t, output logic [1:0] ans);
		@(posedge mclk);
		{req, wr, tgt} <= {1'b1, w, t};
		@(posedge mclk);
		// Released lines flip so stale values never look valid
		{req, wr, tgt} <= {1'b0, ~w, ~t};
		// Answer launched at the sampling edge stands until the next one
		@(posedge mclk);
		ans = {grant, deny};
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Testbench for the debug security lock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk, rst, psel, penable, pwrite, pready, pslverr, preq, pwr, grant, deny, den, e;
	logic [31:0] paddr, pwdata, prdata, r;
	logic [2:0]  ptgt;
	logic [1:0]  ans;
	int          bad_count = 0, check_count = 0;
	debug_security_lock i_debug_security_lock (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.probe_req(preq), .probe_write(pwr), .probe_target(ptgt), .probe_grant(grant), .probe_deny(deny),
		.debug_enable(den));
	probe_model i_probe_model (.mclk(mclk), .req(preq), .wr(pwr), .tgt(ptgt), .grant(grant), .deny(deny));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ==========
	// APB transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		@(posedge mclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			final_report();
		end
		{rd, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task automatic probe(input logic w, input logic [2:0] t, input logic ok);
		i_probe_model.access(w, t, ans);
		check({30'h0, ans}, {30'h0, ok, ~ok});
	endtask
	// ==========
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			check({31'h0, den}, 32'h0);
			apb(1'b0, debug_lock_pkg::security_mode_addr, 32'h0, r);
			check(r, 32'h1);
			apb(1'b1, debug_lock_pkg::security_key_addr, debug_lock_pkg::unlock_key, r);
			check({31'h0, den}, 32'h0);
			probe(1'b1, debug_lock_pkg::tgt_core, 1'b0);
			apb(1'b1, debug_lock_pkg::security_mode_addr, 32'hfffffffe, r);
			apb(1'b0, debug_lock_pkg::security_mode_addr, 32'h0, r);
			check(r, 32'h0);
			apb(1'b1, debug_lock_pkg::security_key_addr, 32'h000000c4, r);
			check({31'h0, den}, 32'h0);
			apb(1'b0, 32'hffffe518, 32'h0, r);
			check({31'h0, e}, 32'h1);
			apb(1'b1, debug_lock_pkg::security_key_addr, debug_lock_pkg::unlock_key, r);
			check({31'h0, den}, 32'h1);
			for (int t = 0; t < 8; t++) begin
				probe(1'b0, 3'(t), 3'(t) != debug_lock_pkg::tgt_rom);
				probe(1'b1, 3'(t), 3'(t) == debug_lock_pkg::tgt_core || 3'(t) == debug_lock_pkg::tgt_ram
					|| 3'(t) == debug_lock_pkg::tgt_ext);
			end
			apb(1'b1, debug_lock_pkg::security_mode_addr, 32'h00000001, r);
			apb(1'b0, debug_lock_pkg::security_mode_addr, 32'h0, r);
			check(r, 32'h1);
			check({31'h0, den}, 32'h1);
			$display("pass %0d done", k);
			rst <= 1'b1;
			repeat (2) @(posedge mclk);
			rst <= 1'b0;
		end
		final_report();
	end
endmodule
`default_nettype wire
